// *** carrier_model.sv ***
// Carrier board model: reset source, strap pins and power switch
`timescale 1ns/1ps
`default_nettype none
module carrier_model (
	input wire logic mclk,
	input wire logic hold_rst,
	input wire logic press_pwr,
	input wire logic [6:0] strap_val,
	output logic master_reset_n_in,
	output logic [6:0] boot_select_straps,
	output logic power_switch_n
);
	logic flip_q = 1'b0;
	always_ff @(posedge mclk) begin
		flip_q <= ~flip_q;
	end
	assign master_reset_n_in = ~hold_rst;
	assign boot_select_straps = {flip_q, strap_val[5:3], flip_q,
		strap_val[1:0]};
	assign power_switch_n = ~press_pwr;
endmodule // carrier_model
`default_nettype wire

// *** module_reset_boot_strap.sv ***
// Module reset, boot strap latch and power switch control
// How it works
// - Module reset output stays low while the module is in reset.
// - Master reset gives a full power-on reset of the processor.
// - Reset ends when master reset releases; no stretch is added.
// - Master reset leaves the power companion state untouched.
// - Straps 1101111 and 1001111 select serial-bus or flash-first orders.
// - Straps 1001110 and 1000110 select execute-in-place or card orders.
// - Power switch acts only once configured and with main supply present.
// - Open-drain regulator enable switches external regulators.
// - Power switch is active low and wakes the off state to run.
`timescale 1ns/1ps
`default_nettype none
`include "reset_strap_defines.svh"
module module_reset_boot_strap #(
	parameter int STRAP_W = `STRAP_W,
	parameter logic [6:0] FIXED_BITS = `STRAP_USB_FIRST
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic master_reset_n_in,
	input wire logic [6:0] boot_select_straps,
	input wire logic power_switch_n,
	input wire logic main_supply_ok,
	input wire logic power_switch_enable,
	input wire logic low_power_request,
	output logic module_reset_n_out,
	output logic cpu_por_n,
	output logic [6:0] boot_strap_latched,
	output reset_strap_pkg::boot_order_t boot_order,
	output reset_strap_pkg::pwr_state_e pwr_state,
	output logic ext_regulator_enable_o,
	output logic ext_regulator_enable_oe_n,
	output logic wake_event
);
	import reset_strap_pkg::*;

	// Decode and ports serve only the seven-bit field
	if (STRAP_W != `STRAP_W) begin : g_bad_width
		$error("Strap field must be seven bits wide");
	end

	function automatic boot_order_t order_of(input logic [6:0] s);
		case (s)
			`STRAP_USB_FIRST: order_of = {SRC_SERIAL_BUS,
				SRC_THIRD_SERIAL_PORT, SRC_CARD_SLOT_ONE,
				SRC_PARALLEL_FLASH, SRC_NONE};
			`STRAP_NAND_FIRST: order_of = {SRC_PARALLEL_FLASH,
				SRC_SERIAL_BUS, SRC_THIRD_SERIAL_PORT,
				SRC_CARD_SLOT_ONE, SRC_NONE};
			`STRAP_XIP_FIRST: order_of = {SRC_EXEC_IN_PLACE_WAIT,
				SRC_DISK_ON_CHIP, SRC_SERIAL_BUS,
				SRC_THIRD_SERIAL_PORT, SRC_CARD_SLOT_ONE};
			`STRAP_CARD_FIRST: order_of = {SRC_CARD_SLOT_ONE,
				SRC_SERIAL_BUS, SRC_NONE, SRC_NONE, SRC_NONE};
			default: order_of = '0;
		endcase
	endfunction

	logic mrst_n_s, pwr_n_s, supply_s;

	sync2 #(.RESET_VAL(1'b0)) u_sync_mrst (
		.mclk(mclk),
		.resetn(resetn),
		.din(master_reset_n_in),
		.dout(mrst_n_s)
	);
	sync2 #(.RESET_VAL(1'b1)) u_sync_pwr (
		.mclk(mclk),
		.resetn(resetn),
		.din(power_switch_n),
		.dout(pwr_n_s)
	);
	sync2 #(.RESET_VAL(1'b0)) u_sync_sup (
		.mclk(mclk),
		.resetn(resetn),
		.din(main_supply_ok),
		.dout(supply_s)
	);

	typedef struct packed {
		// Straps are pins, so they cross two flops first
		logic [6:0] strap_meta;
		logic [6:0] strap_sync;
		logic in_reset;
		logic [6:0] straps;
		boot_order_t order;
		pwr_state_e pstate;
		logic pwr_prev_n;
		logic wake;
	} core_s;
	core_s state_q, state_d;

	always_comb begin
		state_d = state_q;
		state_d.wake = 1'b0;
		state_d.pwr_prev_n = pwr_n_s;
		state_d.strap_meta = boot_select_straps;
		state_d.strap_sync = state_q.strap_meta;
		state_d.in_reset = !mrst_n_s;
		if (!mrst_n_s) begin
			// bits 2 and 6 fixed on module
			state_d.straps = (state_q.strap_sync & ~`STRAP_FIXED_MASK)
				| (FIXED_BITS & `STRAP_FIXED_MASK);
			state_d.order = order_of(state_d.straps);
		end
		case (state_q.pstate)
			ST_RESET: begin
				if (supply_s) begin
					state_d.pstate = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!supply_s) begin
					state_d.pstate = ST_RESET;
				end else if (low_power_request) begin
					state_d.pstate = ST_OFF;
				end
			end
			ST_OFF: begin
				if (!supply_s) begin
					state_d.pstate = ST_RESET;
				end else if (power_switch_enable && state_q.pwr_prev_n
						&& !pwr_n_s) begin
					state_d.pstate = ST_RUN;
					state_d.wake = 1'b1;
				end
			end
			default: state_d.pstate = ST_RESET;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '{strap_meta: '0, strap_sync: '0,
				in_reset: 1'b1, straps: '0, order: '0,
				pstate: ST_RESET, pwr_prev_n: 1'b1, wake: 1'b0};
		end else begin
			state_q <= state_d;
		end
	end

	// reset output and full processor reset
	assign module_reset_n_out = !state_q.in_reset;
	assign cpu_por_n = !state_q.in_reset;
	assign boot_strap_latched = state_q.straps;
	assign boot_order = state_q.order;
	assign pwr_state = state_q.pstate;
	assign wake_event = state_q.wake;
	// open drain: pull low only when regulators off
	assign ext_regulator_enable_o = 1'b0;
	assign ext_regulator_enable_oe_n = (state_q.pstate == ST_RUN);

	// master reset seen released on two edges
	sequence s_run_two;
		mrst_n_s ##1 mrst_n_s;
	endsequence

	// release follows input in fixed time
	a_reset_follow: assert property (@(posedge mclk)
		disable iff (!resetn)
		mrst_n_s |=> module_reset_n_out)
		else $error("Reset output not released");
	a_reset_hold: assert property (@(posedge mclk)
		disable iff (!resetn)
		!mrst_n_s |=> !module_reset_n_out)
		else $error("Reset output not asserted");
	a_strap_hold: assert property (@(posedge mclk)
		disable iff (!resetn)
		s_run_two |=> $stable(boot_strap_latched))
		else $error("Latched straps changed in run");
	// fixed bits; first edge after power reset has no capture yet
	a_fixed_bits: assert property (@(posedge mclk)
		disable iff (!resetn)
		$past(resetn) && !$past(mrst_n_s)
		|-> ((boot_strap_latched & `STRAP_FIXED_MASK)
		== (FIXED_BITS & `STRAP_FIXED_MASK)))
		else $error("Fixed strap bits wrong");
	a_order_dec: assert property (@(posedge mclk)
		disable iff (!resetn)
		!$past(mrst_n_s) |-> boot_order == order_of(boot_strap_latched))
		else $error("Boot order mismatch");
	a_wake_gate: assert property (@(posedge mclk)
		disable iff (!resetn)
		wake_event |-> $past(power_switch_enable) && $past(supply_s))
		else $error("Wake without enable");
	// loss of main supply leaves run and off
	a_supply_loss: assert property (@(posedge mclk)
		disable iff (!resetn)
		!supply_s |=> pwr_state == ST_RESET)
		else $error("Power state kept without supply");
	a_wake_run: assert property (@(posedge mclk)
		disable iff (!resetn)
		wake_event |-> pwr_state == ST_RUN && $past(pwr_state) == ST_OFF)
		else $error("Wake not from off");
	a_wake_pulse: assert property (@(posedge mclk)
		disable iff (!resetn)
		wake_event |=> !wake_event)
		else $error("Wake pulse too long");
	a_reg_enable: assert property (@(posedge mclk)
		disable iff (!resetn)
		(pwr_state == ST_RUN) |-> ext_regulator_enable_oe_n)
		else $error("Regulator held low in run");
	a_pmic_keep: assert property (@(posedge mclk)
		disable iff (!resetn)
		(pwr_state != ST_RESET && !mrst_n_s && supply_s
		&& !low_power_request && !power_switch_enable)
		|=> $stable(pwr_state))
		else $error("Power state disturbed by reset");
endmodule // module_reset_boot_strap
`default_nettype wire

// *** reset_strap_defines.svh ***
// Constants for the module reset and boot strap block
`ifndef RESET_STRAP_DEFINES_SVH
`define RESET_STRAP_DEFINES_SVH
`define STRAP_W 7
`define STRAP_USB_FIRST 7'h6F
`define STRAP_NAND_FIRST 7'h4F
`define STRAP_XIP_FIRST 7'h4E
`define STRAP_CARD_FIRST 7'h46
`define STRAP_FIXED_MASK 7'h44
`define SRC_W 3
`define ORDER_LEN 5
`define PWR_FILTER_CYCLES 4
`endif

// *** reset_strap_pkg.sv ***
// Types for the module reset and boot strap block
package reset_strap_pkg;
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_SERIAL_BUS = 3'h1,
		SRC_THIRD_SERIAL_PORT = 3'h2,
		SRC_CARD_SLOT_ONE = 3'h3,
		SRC_PARALLEL_FLASH = 3'h4,
		SRC_EXEC_IN_PLACE_WAIT = 3'h5,
		SRC_DISK_ON_CHIP = 3'h6
	} boot_src_e;
	typedef logic [14:0] boot_order_t;
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_RUN = 2'b01,
		ST_OFF = 2'b11
	} pwr_state_e;
endpackage

// *** sync2.sv ***
// Two flip-flop synchroniser for a level input
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic meta;
		logic stable;
	} sync_s;
	sync_s state_q, state_d;
	always_comb begin
		state_d = state_q;
		state_d.meta = din;
		state_d.stable = state_q.meta;
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '{meta: RESET_VAL, stable: RESET_VAL};
		end else begin
			state_q <= state_d;
		end
	end
	assign dout = state_q.stable;
endmodule // sync2
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the module reset and boot strap block
`timescale 1ns/1ps
`default_nettype none
`include "reset_strap_defines.svh"
module testbench;
	import reset_strap_pkg::*;
	typedef struct packed {
		logic [6:0] s;
		boot_order_t o;
	} row_s;
	row_s rows [4] = '{'{7'h4F, 15'h4298}, '{7'h4E, 15'h5C53},
		'{7'h46, 15'h3200}, '{7'h47, 15'h0000}};
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic hold_rst = 1'b0;
	logic press_pwr = 1'b0;
	logic [6:0] strap_val = 7'h00;
	logic main_supply_ok = 1'b0;
	logic power_switch_enable = 1'b0;
	logic low_power_request = 1'b0;
	logic master_reset_n_in, power_switch_n, module_reset_n_out, cpu_por_n;
	logic [6:0] boot_select_straps, boot_strap_latched;
	boot_order_t boot_order;
	pwr_state_e pwr_state;
	logic ext_regulator_enable_o, ext_regulator_enable_oe_n, wake_event;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	carrier_model i_carrier_model (.mclk(mclk), .hold_rst(hold_rst),
		.press_pwr(press_pwr), .strap_val(strap_val),
		.master_reset_n_in(master_reset_n_in),
		.boot_select_straps(boot_select_straps),
		.power_switch_n(power_switch_n));
	module_reset_boot_strap #(.FIXED_BITS(`STRAP_NAND_FIRST))
	i_module_reset_boot_strap (.mclk(mclk), .resetn(resetn),
		.master_reset_n_in(master_reset_n_in),
		.boot_select_straps(boot_select_straps),
		.power_switch_n(power_switch_n), .main_supply_ok(main_supply_ok),
		.power_switch_enable(power_switch_enable),
		.low_power_request(low_power_request),
		.module_reset_n_out(module_reset_n_out), .cpu_por_n(cpu_por_n),
		.boot_strap_latched(boot_strap_latched), .boot_order(boot_order),
		.pwr_state(pwr_state),
		.ext_regulator_enable_o(ext_regulator_enable_o),
		.ext_regulator_enable_oe_n(ext_regulator_enable_oe_n),
		.wake_event(wake_event));
	always #2 mclk = ~mclk;
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Hang guard, run needs under a hundred cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		tick(12);
		resetn = 1'b1;
		main_supply_ok = 1'b1;
		tick(5);
		foreach (rows[i]) begin
			hold_rst = 1'b1;
			strap_val = rows[i].s;
			tick(4);
			check(module_reset_n_out, 1'b0);
			check(cpu_por_n, 1'b0);
			check(pwr_state, ST_RUN);
			hold_rst = 1'b0;
			tick(2);
			check(module_reset_n_out, 1'b0);
			tick(1);
			check(module_reset_n_out, 1'b1);
			strap_val = ~rows[i].s;
			tick(3);
			check(boot_strap_latched, rows[i].s);
			check(boot_order, rows[i].o);
			$display("Strap row %0d done", i);
		end
		check(ext_regulator_enable_oe_n, 1'b1);
		low_power_request = 1'b1;
		tick(4);
		low_power_request = 1'b0;
		check(pwr_state, ST_OFF);
		check(ext_regulator_enable_oe_n, 1'b0);
		check(ext_regulator_enable_o, 1'b0);
		press_pwr = 1'b1;
		tick(6);
		press_pwr = 1'b0;
		check(pwr_state, ST_OFF);
		tick(2);
		power_switch_enable = 1'b1;
		press_pwr = 1'b1;
		repeat (6) if (wake_event !== 1'b1) tick(1);
		check(wake_event, 1'b1);
		tick(1);
		check(wake_event, 1'b0);
		check(pwr_state, ST_RUN);
		press_pwr = 1'b0;
		$display("Power switch test done");
		main_supply_ok = 1'b0;
		tick(3);
		check(pwr_state, ST_RESET);
		check(ext_regulator_enable_oe_n, 1'b0);
		press_pwr = 1'b1;
		tick(4);
		check(wake_event, 1'b0);
		check(pwr_state, ST_RESET);
		press_pwr = 1'b0;
		main_supply_ok = 1'b1;
		tick(4);
		check(pwr_state, ST_RUN);
		$display("Supply loss test done");
		resetn = 1'b0;
		tick(1);
		check(module_reset_n_out, 1'b0);
		check(boot_order, 15'h0000);
		check(pwr_state, ST_RESET);
		$display("Reset test done");
		resetn = 1'b1;
		summarize();
	end
endmodule // testbench
`default_nettype wire
